// >>> verilog/mrs_consts.svh
// Constants of the reset sequencer: timing, codes, offsets, bits
// Behaviour
// - Power-on reset zeroes the program counter; execution starts at address zero.
// - Power-on presets every port data and direction register to ones: inputs.
// - After power-on the core stays in reset for the 50 ms delay.
// - Pin reset works only when the option selects it; else plain I/O.
// - Pin low holds reset; after release wait a further 16.7 ms.
// - Pin reset keeps some registers, zeroes the counter, restarts at zero.
// - A valid brownout resets the device and sets the brownout flag.
// - Low supply no longer than the minimum duration is ignored.
// - Level codes 55, 33, 99, aa pick the four thresholds; only these.
// - Invalid level code resets after 2~3 sub clocks and restores 55.
// - A reset from an invalid level code sets the config fault flag.
// - Genuine brownout resets after 2~3 sub clocks, level code kept.
// - Level code register holds 55 after power-on.
// - Brownout reset is disabled while in power-down mode.
// - Brownout flags set only by hardware, cleared only by writing zero.
// - Watchdog time-out while running acts as pin reset and sets time-out flag.
// - Watchdog time-out asleep clears only counter and stack, sets time-out flag.
// - Start-up wait: 15~16 RC clocks, 1024 crystal clocks, 1~2 slow RC clocks.
// - Power-on clears both flags; pin/brownout keep; watchdog sets as described.
// - After reset clear watchdog and time base, then let watchdog count.
// - After reset interrupts off, timers off, stack pointer at top.
// - Invalid watchdog enable code resets after 2~3 clocks, sets sticky fault.
`ifndef MRS_CONSTS_SVH
`define MRS_CONSTS_SVH
`define MRS_CLK_MHZ         100
`define MRS_T_POR_US        50000
`define MRS_T_PIN_US        16700
`define MRS_POR_CYC         (`MRS_T_POR_US * `MRS_CLK_MHZ)
`define MRS_PIN_CYC         (`MRS_T_PIN_US * `MRS_CLK_MHZ)
`define MRS_BO_MIN_CYC      100
`define MRS_FAULT_EDGES     2'h2
`define MRS_SST_RC          11'h010
`define MRS_SST_XTAL        11'h400
`define MRS_SST_INT_SLOW_RC_OSC        11'h002
`define MRS_BO_CODE_A       8'h55
`define MRS_BO_CODE_B       8'h33
`define MRS_BO_CODE_C       8'h99
`define MRS_BO_CODE_D       8'haa
`define MRS_BO_RST          8'h55
`define MRS_WD_ON           5'h0a
`define MRS_WD_OFF          5'h15
`define MRS_ADDR_LEVEL      4'h0
`define MRS_ADDR_CAUSE      4'h1
`define MRS_ADDR_FLAGS      4'h2
`define MRS_B_KEEP          7
`define MRS_B_BOF           2
`define MRS_B_BOCF          1
`define MRS_B_WDCF          0
`define MRS_B_TO            0
`define MRS_B_PDF           1
`endif

// >>> verilog/mrs_pkg.sv
// Types shared by the reset sequencer
package mrs_pkg;
  typedef enum logic [2:0] {
    MRS_OSC_ERC,
    MRS_OSC_INT_FAST_RC_OSC,
    MRS_OSC_HXT,
    MRS_OSC_LXT,
    MRS_OSC_INT_SLOW_RC_OSC
  } mrs_osc_e;

  typedef enum logic [1:0] {
    MRS_S_DELAY,
    MRS_S_PIN_HOLD,
    MRS_S_RUN,
    MRS_S_WAKE
  } mrs_state_e;

  typedef struct packed {
    logic bo;
    logic bocf;
    logic wdcf;
  } mrs_fault_s;
endpackage

// >>> verilog/mrs_top.sv
// Reset sequencer: sources, delays, cause flags and registers
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`include "mrs_consts.svh"
module mrs_top #(
  parameter int unsigned POR_CYC    = `MRS_POR_CYC,
  parameter int unsigned PIN_CYC    = `MRS_PIN_CYC,
  parameter int unsigned BO_MIN_CYC = `MRS_BO_MIN_CYC,
  parameter int unsigned CNT_W      = 24,
  parameter int unsigned AW         = 4
) (
  input  logic               core_clk_i,
  input  logic               rstn_i,
  input  logic               ext_reset_pin_n_i,
  input  logic               ext_reset_enable_i,
  input  logic               brownout_low_i,
  input  logic               powerdown_i,
  input  logic               sleep_idle_i,
  input  logic               wake_i,
  input  logic               wdt_timeout_i,
  input  logic               wdt_always_on_i,
  input  logic [4:0]         watchdog_enable_code_i,
  input  logic               sub_clk_i,
  input  logic               sys_osc_clk_i,
  input  mrs_pkg::mrs_osc_e  osc_sel_i,
  input  logic [AW-1:0]      addr_i,
  input  logic [7:0]         wdata_i,
  input  logic               wr_i,
  input  logic               rd_i,
  output logic [7:0]         rdata_o,
  output logic               core_rst_n_o,
  output logic               pc_sp_clear_o,
  output logic               wdt_clear_o,
  output logic               wdt_run_o,
  output logic               core_run_o,
  output logic [1:0]         bo_level_o,
  output logic               ext_pin_io_o,
  output logic               idle_sysclk_keep_o,
  output logic               to_flag_o,
  output logic               pdf_flag_o
);

  localparam int unsigned BO_W = $clog2(BO_MIN_CYC + 1);

  if (CNT_W < 11 || AW < 2 || POR_CYC < 1 || PIN_CYC < 1 ||
      BO_MIN_CYC < 1 || BO_W < 1 ||
      64'(POR_CYC) > (64'h1 << CNT_W) ||
      64'(PIN_CYC) > (64'h1 << CNT_W)) begin : g_bad_param
    $error("mrs_top: parameter values out of range");
  end

  localparam logic [CNT_W-1:0] POR_LOAD = CNT_W'(POR_CYC - 1);
  localparam logic [CNT_W-1:0] PIN_LOAD = CNT_W'(PIN_CYC - 1);
  localparam logic [BO_W-1:0]  BO_MIN   = BO_W'(BO_MIN_CYC);

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  function automatic logic bo_code_ok(input logic [7:0] c);
    bo_code_ok = (c == `MRS_BO_CODE_A) || (c == `MRS_BO_CODE_B) ||
                 (c == `MRS_BO_CODE_C) || (c == `MRS_BO_CODE_D);
  endfunction

  function automatic logic wd_code_ok(input logic [4:0] c);
    wd_code_ok = (c == `MRS_WD_ON) || (c == `MRS_WD_OFF);
  endfunction

  function automatic logic [10:0] sst_len(input mrs_pkg::mrs_osc_e o);
    case (o)
      mrs_pkg::MRS_OSC_HXT,
      mrs_pkg::MRS_OSC_LXT:  sst_len = `MRS_SST_XTAL;
      mrs_pkg::MRS_OSC_INT_SLOW_RC_OSC: sst_len = `MRS_SST_INT_SLOW_RC_OSC;
      default:               sst_len = `MRS_SST_RC;
    endcase
  endfunction

  function automatic logic [1:0] bo_thr(input logic [7:0] c);
    case (c)
      `MRS_BO_CODE_B: bo_thr = 2'h1;
      `MRS_BO_CODE_C: bo_thr = 2'h2;
      `MRS_BO_CODE_D: bo_thr = 2'h3;
      default:        bo_thr = 2'h0;
    endcase
  endfunction

  // Sequencer state
  mrs_pkg::mrs_state_e st_r;
  mrs_pkg::mrs_state_e st_nxt;
  logic [CNT_W-1:0]    cnt_r;
  logic [CNT_W-1:0]    cnt_nxt;
  mrs_pkg::mrs_fault_s pend_r;
  mrs_pkg::mrs_fault_s pend_nxt;
  mrs_pkg::mrs_fault_s fire;
  logic [1:0]          pcnt_r;
  logic [1:0]          pcnt_nxt;
  logic [BO_W-1:0]     bo_cnt_r;
  logic [BO_W-1:0]     bo_cnt_nxt;
  logic                sub_prev_r;
  logic                sys_prev_r;
  logic                sub_e;
  logic                sys_e;
  logic                bo_valid;
  logic                pin_rst;
  logic                armed;
  logic                rel;
  logic                wdt_slp;
  logic                wdt_norm;
  logic                core_rst_n_nxt;
  logic                pc_sp_clear_nxt;
  logic                wdt_clear_nxt;
  logic                wdt_run_nxt;
  logic                core_run_nxt;
  logic                ext_pin_io_nxt;

  // Register state
  logic [7:0]          level_r;
  logic [7:0]          level_nxt;
  logic                keep_nxt;
  logic                bof_r;
  logic                bof_nxt;
  logic                bocf_r;
  logic                bocf_nxt;
  logic                wdcf_r;
  logic                wdcf_nxt;
  logic                to_nxt;
  logic                pdf_nxt;
  logic [1:0]          bo_level_nxt;
  logic [7:0]          rdata_nxt;
  logic                wr_level;
  logic                wr_cause;
  logic                wr_flags;

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    pend_nxt  = pend_r;
    pcnt_nxt  = pcnt_r;
    fire      = '0;
    rel       = 1'b0;
    wdt_slp   = 1'b0;
    wdt_norm  = 1'b0;
    sub_e     = rise(sub_clk_i, sub_prev_r);
    sys_e     = rise(sys_osc_clk_i, sys_prev_r);
    pin_rst   = ext_reset_enable_i & ~ext_reset_pin_n_i;
    armed     = (st_r == mrs_pkg::MRS_S_RUN) ||
                (st_r == mrs_pkg::MRS_S_WAKE);
    // Glitch filter; off in power-down
    if (powerdown_i || !brownout_low_i) begin
      bo_cnt_nxt = '0;
    end else if (bo_cnt_r != BO_MIN) begin
      bo_cnt_nxt = bo_cnt_r + BO_W'(1);
    end else begin
      bo_cnt_nxt = bo_cnt_r;
    end
    bo_valid = !powerdown_i && brownout_low_i && (bo_cnt_r == BO_MIN);
    if (bo_valid) begin
      pend_nxt.bo = 1'b1;
    end
    if (!bo_code_ok(level_r)) begin
      pend_nxt.bocf = 1'b1;
    end
    if (armed && !wd_code_ok(watchdog_enable_code_i)) begin
      pend_nxt.wdcf = 1'b1;
    end
    // Third sub clock edge: 2~3 periods after detection
    if (pend_r != '0 && sub_e) begin
      if (pcnt_r == `MRS_FAULT_EDGES) begin
        fire     = pend_r;
        pend_nxt = '0;
        pcnt_nxt = '0;
      end else begin
        pcnt_nxt = pcnt_r + 2'h1;
      end
    end
    case (st_r)
      mrs_pkg::MRS_S_DELAY: begin
        if (cnt_r == '0) begin
          st_nxt = mrs_pkg::MRS_S_RUN;
          rel    = 1'b1;
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      mrs_pkg::MRS_S_PIN_HOLD: begin
        if (ext_reset_pin_n_i || !ext_reset_enable_i) begin
          st_nxt  = mrs_pkg::MRS_S_DELAY;
          cnt_nxt = PIN_LOAD;
        end
      end
      mrs_pkg::MRS_S_RUN: begin
        if (wdt_timeout_i && sleep_idle_i) begin
          wdt_slp = 1'b1;
          st_nxt  = mrs_pkg::MRS_S_WAKE;
          cnt_nxt = CNT_W'(sst_len(osc_sel_i));
        end else if (wdt_timeout_i) begin
          wdt_norm = 1'b1;
          st_nxt   = mrs_pkg::MRS_S_DELAY;
          cnt_nxt  = PIN_LOAD;
        end else if (wake_i) begin
          st_nxt  = mrs_pkg::MRS_S_WAKE;
          cnt_nxt = CNT_W'(sst_len(osc_sel_i));
        end
      end
      mrs_pkg::MRS_S_WAKE: begin
        if (sys_e) begin
          if (cnt_r <= CNT_W'(1)) begin
            st_nxt  = mrs_pkg::MRS_S_RUN;
            cnt_nxt = '0;
          end else begin
            cnt_nxt = cnt_r - CNT_W'(1);
          end
        end
      end
      default: begin
        st_nxt  = mrs_pkg::MRS_S_DELAY;
        cnt_nxt = POR_LOAD;
      end
    endcase
    if (fire != '0) begin
      st_nxt   = mrs_pkg::MRS_S_DELAY;
      cnt_nxt  = POR_LOAD;
      rel      = 1'b0;
      wdt_slp  = 1'b0;
      wdt_norm = 1'b0;
    end
    if (pin_rst) begin
      st_nxt   = mrs_pkg::MRS_S_PIN_HOLD;
      cnt_nxt  = PIN_LOAD;
      rel      = 1'b0;
      wdt_slp  = 1'b0;
      wdt_norm = 1'b0;
    end
    // Core and peripherals held while not running or waking
    core_rst_n_nxt  = (st_nxt == mrs_pkg::MRS_S_RUN) ||
                      (st_nxt == mrs_pkg::MRS_S_WAKE);
    pc_sp_clear_nxt = !core_rst_n_nxt || wdt_slp;
    wdt_clear_nxt   = rel;
    wdt_run_nxt     = core_rst_n_nxt && !rel &&
                      (wdt_always_on_i ||
                       watchdog_enable_code_i == `MRS_WD_ON);
    core_run_nxt    = (st_nxt == mrs_pkg::MRS_S_RUN);
    ext_pin_io_nxt  = ext_reset_enable_i ? 1'b1 : ext_reset_pin_n_i;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r          <= mrs_pkg::MRS_S_DELAY;
      cnt_r         <= POR_LOAD;
      pend_r        <= '0;
      pcnt_r        <= 2'h0;
      bo_cnt_r      <= '0;
      sub_prev_r    <= 1'b0;
      sys_prev_r    <= 1'b0;
      core_rst_n_o  <= 1'b0;
      pc_sp_clear_o <= 1'b1;
      wdt_clear_o   <= 1'b0;
      wdt_run_o     <= 1'b0;
      core_run_o    <= 1'b0;
      ext_pin_io_o  <= 1'b1;
    end else begin
      st_r          <= st_nxt;
      cnt_r         <= cnt_nxt;
      pend_r        <= pend_nxt;
      pcnt_r        <= pcnt_nxt;
      bo_cnt_r      <= bo_cnt_nxt;
      sub_prev_r    <= sub_clk_i;
      sys_prev_r    <= sys_osc_clk_i;
      core_rst_n_o  <= core_rst_n_nxt;
      pc_sp_clear_o <= pc_sp_clear_nxt;
      wdt_clear_o   <= wdt_clear_nxt;
      wdt_run_o     <= wdt_run_nxt;
      core_run_o    <= core_run_nxt;
      ext_pin_io_o  <= ext_pin_io_nxt;
    end
  end

  always_comb begin
    wr_level  = wr_i && (addr_i == AW'(`MRS_ADDR_LEVEL));
    wr_cause  = wr_i && (addr_i == AW'(`MRS_ADDR_CAUSE));
    wr_flags  = wr_i && (addr_i == AW'(`MRS_ADDR_FLAGS));
    level_nxt = wr_level ? wdata_i : level_r;
    if (fire.bocf) begin
      level_nxt = `MRS_BO_RST;
    end
    keep_nxt = wr_cause ? wdata_i[`MRS_B_KEEP] : idle_sysclk_keep_o;
    // Software may only clear; a set in the same cycle wins
    bof_nxt  = bof_r  & ~(wr_cause & ~wdata_i[`MRS_B_BOF]);
    bocf_nxt = bocf_r & ~(wr_cause & ~wdata_i[`MRS_B_BOCF]);
    wdcf_nxt = wdcf_r & ~(wr_cause & ~wdata_i[`MRS_B_WDCF]);
    to_nxt   = to_flag_o  & ~(wr_flags & ~wdata_i[`MRS_B_TO]);
    pdf_nxt  = pdf_flag_o & ~(wr_flags & ~wdata_i[`MRS_B_PDF]);
    if (fire.bo) begin
      bof_nxt = 1'b1;
    end
    if (fire.bocf) begin
      bocf_nxt = 1'b1;
    end
    if (fire.wdcf) begin
      wdcf_nxt = 1'b1;
    end
    if (wdt_norm || wdt_slp) begin
      to_nxt = 1'b1;
    end
    if (wdt_slp) begin
      pdf_nxt = 1'b1;
    end
    bo_level_nxt = bo_thr(level_nxt);
    rdata_nxt    = 8'h00;
    if (rd_i) begin
      case (addr_i)
        AW'(`MRS_ADDR_LEVEL): rdata_nxt = level_r;
        AW'(`MRS_ADDR_CAUSE): begin
          rdata_nxt[`MRS_B_KEEP] = idle_sysclk_keep_o;
          rdata_nxt[`MRS_B_BOF]  = bof_r;
          rdata_nxt[`MRS_B_BOCF] = bocf_r;
          rdata_nxt[`MRS_B_WDCF] = wdcf_r;
        end
        AW'(`MRS_ADDR_FLAGS): begin
          rdata_nxt[`MRS_B_TO]  = to_flag_o;
          rdata_nxt[`MRS_B_PDF] = pdf_flag_o;
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      level_r            <= `MRS_BO_RST;
      idle_sysclk_keep_o <= 1'b0;
      bof_r              <= 1'b0;
      bocf_r             <= 1'b0;
      wdcf_r             <= 1'b0;
      to_flag_o          <= 1'b0;
      pdf_flag_o         <= 1'b0;
      bo_level_o         <= 2'h0;
      rdata_o            <= 8'h00;
    end else begin
      level_r            <= level_nxt;
      idle_sysclk_keep_o <= keep_nxt;
      bof_r              <= bof_nxt;
      bocf_r             <= bocf_nxt;
      wdcf_r             <= wdcf_nxt;
      to_flag_o          <= to_nxt;
      pdf_flag_o         <= pdf_nxt;
      bo_level_o         <= bo_level_nxt;
      rdata_o            <= rdata_nxt;
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  property p_pin_hold;
    pin_rst |=> !core_rst_n_o ##1 !core_rst_n_o;
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("pin reset did not hold the core");

  property p_pin_delay;
    (st_r == mrs_pkg::MRS_S_PIN_HOLD && !pin_rst)
      |=> (st_r == mrs_pkg::MRS_S_DELAY) && (cnt_r == PIN_LOAD);
  endproperty
  a_pin_delay: assert property (p_pin_delay)
    else $error("pin release did not load the short delay");

  property p_release;
    $rose(core_rst_n_o) && $past(st_r) == mrs_pkg::MRS_S_DELAY
      |-> $past(cnt_r) == '0 && wdt_clear_o && pc_sp_clear_o == 1'b0;
  endproperty
  a_release: assert property (p_release)
    else $error("reset released before its delay ran out");

  property p_fault_wait;
    fire != '0 |-> pcnt_r == `MRS_FAULT_EDGES && sub_e && pend_r != '0;
  endproperty
  a_fault_wait: assert property (p_fault_wait)
    else $error("fault reset fired on the wrong sub clock edge");

  property p_code_restore;
    fire.bocf |=> level_r == `MRS_BO_RST && bocf_r && !core_rst_n_o;
  endproperty
  a_code_restore: assert property (p_code_restore)
    else $error("bad level code not restored or not flagged");

  property p_code_keep;
    fire.bo && !fire.bocf && !wr_level |=> $stable(level_r) && bof_r;
  endproperty
  a_code_keep: assert property (p_code_keep)
    else $error("brownout reset changed the level code");

  property p_sticky;
    bof_r && !(wr_cause && !wdata_i[`MRS_B_BOF]) |=> bof_r;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("brownout flag cleared without a software write");

  property p_pd_off;
    powerdown_i |=> bo_cnt_r == '0 ##1 !bo_valid;
  endproperty
  a_pd_off: assert property (p_pd_off)
    else $error("brownout filter ran in power-down");

  property p_sleep_wdt;
    wdt_slp && !pin_rst && fire == '0
      |=> pc_sp_clear_o && to_flag_o && pdf_flag_o && core_rst_n_o
      ##1 !pc_sp_clear_o;
  endproperty
  a_sleep_wdt: assert property (p_sleep_wdt)
    else $error("sleep time-out did more than clear counter and stack");

  property p_run_wdt;
    wdt_norm |=> !core_rst_n_o && to_flag_o && $stable(pdf_flag_o);
  endproperty
  a_run_wdt: assert property (p_run_wdt)
    else $error("running time-out did not reset or set the flag");

endmodule

// >>> sim/tb.sv
// Self-checking bench of the reset sequencer
`timescale 1ns/1ps
`include "mrs_consts.svh"
`define CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); \
  end \
end
module tb;
  localparam int POR  = 50;
  localparam int PIN  = 20;
  localparam int BOM  = 4;
  localparam int SUBP = 8;
  localparam int OSCP = 4;
  localparam logic [7:0] CODES [4] = '{`MRS_BO_CODE_A, `MRS_BO_CODE_B,
                                      `MRS_BO_CODE_C, `MRS_BO_CODE_D};
  localparam int SST_LO [5] = '{15, 15, 1024, 1024, 1};
  localparam int SST_HI [5] = '{16, 16, 1024, 1024, 2};
  logic              core_clk_i = 1'b0;
  logic              rstn_i;
  logic              ext_reset_pin_n_i;
  logic              ext_reset_enable_i;
  logic              brownout_low_i;
  logic              powerdown_i;
  logic              sleep_idle_i;
  logic              wake_i;
  logic              wdt_timeout_i;
  logic              wdt_always_on_i;
  logic [4:0]        watchdog_enable_code_i;
  logic              sub_clk_i;
  logic              sys_osc_clk_i;
  mrs_pkg::mrs_osc_e osc_sel_i;
  logic [3:0]        addr_i;
  logic [7:0]        wdata_i;
  logic              wr_i;
  logic              rd_i;
  logic [7:0]        rdata_o;
  logic              core_rst_n_o;
  logic              pc_sp_clear_o;
  logic              wdt_clear_o;
  logic              wdt_run_o;
  logic              core_run_o;
  logic [1:0]        bo_level_o;
  logic              ext_pin_io_o;
  logic              idle_sysclk_keep_o;
  logic              to_flag_o;
  logic              pdf_flag_o;
  int                mismatches = 0;
  int                compares = 0;
  int                seed = 49;
  int                tick = 0;

  mrs_top #(.POR_CYC(POR), .PIN_CYC(PIN), .BO_MIN_CYC(BOM)) dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .ext_reset_pin_n_i(ext_reset_pin_n_i),
    .ext_reset_enable_i(ext_reset_enable_i),
    .brownout_low_i(brownout_low_i), .powerdown_i(powerdown_i),
    .sleep_idle_i(sleep_idle_i), .wake_i(wake_i),
    .wdt_timeout_i(wdt_timeout_i), .wdt_always_on_i(wdt_always_on_i),
    .watchdog_enable_code_i(watchdog_enable_code_i),
    .sub_clk_i(sub_clk_i), .sys_osc_clk_i(sys_osc_clk_i),
    .osc_sel_i(osc_sel_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .core_rst_n_o(core_rst_n_o), .pc_sp_clear_o(pc_sp_clear_o),
    .wdt_clear_o(wdt_clear_o), .wdt_run_o(wdt_run_o),
    .core_run_o(core_run_o), .bo_level_o(bo_level_o),
    .ext_pin_io_o(ext_pin_io_o), .idle_sysclk_keep_o(idle_sysclk_keep_o),
    .to_flag_o(to_flag_o), .pdf_flag_o(pdf_flag_o));

  always #5 core_clk_i = ~core_clk_i;

  // Sub clock and system oscillator run free as slow levels
  always @(posedge core_clk_i) begin
    tick <= tick + 1;
    if (tick % (SUBP / 2) == SUBP / 2 - 1) sub_clk_i <= ~sub_clk_i;
    if (tick % (OSCP / 2) == OSCP / 2 - 1) sys_osc_clk_i <= ~sys_osc_clk_i;
  end

  function automatic logic in_rng(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi);
  endfunction

  function automatic logic is_code(input logic [7:0] c);
    return c == CODES[0] || c == CODES[1] || c == CODES[2] || c == CODES[3];
  endfunction

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
                        input string nm);
    logic [7:0] d;
    @(posedge core_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    `CHK(nm, e, d)
  endtask

  // Cycles until the core reset releases, bounded
  task automatic rise_wait(output int n);
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1 n++;
    end while (core_rst_n_o !== 1'b1 && n < 3000);
  endtask

  task automatic low_wait(output int n);
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1 n++;
    end while (core_rst_n_o !== 1'b0 && n < 200);
  endtask

  task automatic quiet(input int cyc, input string nm);
    repeat (cyc) @(posedge core_clk_i);
    #1;
    `CHK(nm, 1'b1, core_rst_n_o)
  endtask

  initial begin
    #400000;
    mismatches++;
    wrap_up();
  end

  initial begin
    logic [7:0] c;
    int         n;
    int         k;
    {rstn_i, brownout_low_i, powerdown_i, sleep_idle_i, wake_i} = '0;
    {wdt_timeout_i, wdt_always_on_i, sub_clk_i, sys_osc_clk_i} = '0;
    {addr_i, wdata_i, wr_i, rd_i, ext_reset_enable_i} = '0;
    ext_reset_pin_n_i = 1'b1;
    watchdog_enable_code_i = `MRS_WD_ON;
    osc_sel_i = mrs_pkg::MRS_OSC_ERC;
    repeat (12) @(posedge core_clk_i);
    #1;
    `CHK("por_rst", 1'b0, core_rst_n_o)
    `CHK("por_pcsp", 1'b1, pc_sp_clear_o)
    `CHK("por_pin_in", 1'b1, ext_pin_io_o)
    @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rise_wait(n);
    `CHK("por_delay", POR, n)
    `CHK("wdt_clear", 1'b1, wdt_clear_o)
    `CHK("wdt_hold", 1'b0, wdt_run_o)
    @(posedge core_clk_i);
    #1;
    `CHK("wdt_count", 1'b1, wdt_run_o)
    rd_chk(`MRS_ADDR_LEVEL, `MRS_BO_RST, "level_por");
    rd_chk(`MRS_ADDR_FLAGS, 8'h00, "flags_por");
    rd_chk(`MRS_ADDR_CAUSE, 8'h00, "cause_por");
    for (k = 0; k < 4; k++) begin
      wr(`MRS_ADDR_LEVEL, CODES[k]);
      @(posedge core_clk_i);
      #1;
      `CHK("bo_level", k[1:0], bo_level_o)
      rd_chk(`MRS_ADDR_LEVEL, CODES[k], "level_rb");
    end
    k = 3 + $unsigned($random(seed)) % 13;
    wr(k[3:0], 8'hff);
    rd_chk(k[3:0], 8'h00, "unmapped");
    // Pin as plain I/O while the option is off
    @(posedge core_clk_i);
    ext_reset_pin_n_i <= 1'b0;
    quiet(3, "pin_off_rst");
    `CHK("pin_io", 1'b0, ext_pin_io_o)
    @(posedge core_clk_i);
    ext_reset_pin_n_i <= 1'b1;
    @(posedge core_clk_i);
    ext_reset_enable_i <= 1'b1;
    quiet(2, "pin_en_rst");
    `CHK("pin_io_rst", 1'b1, ext_pin_io_o)
    // Watchdog time-out while running
    @(posedge core_clk_i);
    wdt_timeout_i <= 1'b1;
    @(posedge core_clk_i);
    wdt_timeout_i <= 1'b0;
    #1;
    `CHK("wdt_run_rst", 1'b0, core_rst_n_o)
    `CHK("to_run", 1'b1, to_flag_o)
    `CHK("pdf_run", 1'b0, pdf_flag_o)
    rise_wait(n);
    `CHK("wdt_delay", 1'b1, in_rng(n, PIN - 1, PIN + 2))
    // Pin reset of random length
    @(posedge core_clk_i);
    ext_reset_pin_n_i <= 1'b0;
    n = 1 + $unsigned($random(seed)) % 8;
    repeat (n) @(posedge core_clk_i);
    #1;
    `CHK("pin_rst", 1'b0, core_rst_n_o)
    `CHK("pin_pcsp", 1'b1, pc_sp_clear_o)
    @(posedge core_clk_i);
    ext_reset_pin_n_i <= 1'b1;
    rise_wait(n);
    `CHK("pin_delay", 1'b1, in_rng(n, PIN, PIN + 2))
    `CHK("to_kept", 1'b1, to_flag_o)
    wr(`MRS_ADDR_FLAGS, 8'h00);
    // Brownout: short pulse, power-down, then genuine
    c = CODES[$unsigned($random(seed)) % 4];
    wr(`MRS_ADDR_LEVEL, c);
    @(posedge core_clk_i);
    brownout_low_i <= 1'b1;
    repeat (BOM) @(posedge core_clk_i);
    brownout_low_i <= 1'b0;
    quiet(4 * SUBP, "bo_short");
    @(posedge core_clk_i);
    powerdown_i    <= 1'b1;
    brownout_low_i <= 1'b1;
    quiet(6 * SUBP, "bo_pdown");
    @(posedge core_clk_i);
    powerdown_i    <= 1'b0;
    brownout_low_i <= 1'b0;
    @(posedge core_clk_i);
    brownout_low_i <= 1'b1;
    // Drop once latched, so a still-low supply cannot refire
    repeat (BOM + 1) @(posedge core_clk_i);
    brownout_low_i <= 1'b0;
    low_wait(n);
    `CHK("bo_time", 1'b1, in_rng(n, 2 * SUBP - 2, 3 * SUBP + 6))
    @(posedge core_clk_i);
    brownout_low_i <= 1'b0;
    rise_wait(n);
    `CHK("bo_delay", 1'b1, in_rng(n, POR - 1, POR + 2))
    rd_chk(`MRS_ADDR_LEVEL, c, "bo_level_kept");
    rd_chk(`MRS_ADDR_CAUSE, 8'h04, "bo_flag");
    c = $random(seed);
    wr(`MRS_ADDR_CAUSE, c | 8'h07);
    rd_chk(`MRS_ADDR_CAUSE, {c[7], 7'h04}, "flag_sticky");
    `CHK("idle_keep", c[7], idle_sysclk_keep_o)
    wr(`MRS_ADDR_CAUSE, 8'h00);
    rd_chk(`MRS_ADDR_CAUSE, 8'h00, "flag_clear");
    // Invalid level code
    do c = $random(seed); while (is_code(c));
    wr(`MRS_ADDR_LEVEL, c);
    low_wait(n);
    `CHK("lvl_time", 1'b1, in_rng(n, 2 * SUBP - 2, 3 * SUBP + 6))
    rise_wait(n);
    rd_chk(`MRS_ADDR_LEVEL, `MRS_BO_RST, "lvl_restore");
    `CHK("lvl_sel", 2'h0, bo_level_o)
    rd_chk(`MRS_ADDR_CAUSE, 8'h02, "lvl_flag");
    wr(`MRS_ADDR_CAUSE, 8'h00);
    // Watchdog enable code: valid off code, then invalid code
    @(posedge core_clk_i);
    wdt_always_on_i        <= 1'b1;
    watchdog_enable_code_i <= `MRS_WD_OFF;
    quiet(4 * SUBP, "wd_valid");
    do k = $unsigned($random(seed)) % 32; while (k == 10 || k == 21);
    @(posedge core_clk_i);
    wdt_always_on_i        <= 1'b0;
    watchdog_enable_code_i <= k[4:0];
    low_wait(n);
    `CHK("wd_time", 1'b1, in_rng(n, 2 * SUBP - 2, 3 * SUBP + 6))
    @(posedge core_clk_i);
    watchdog_enable_code_i <= `MRS_WD_ON;
    rise_wait(n);
    rd_chk(`MRS_ADDR_CAUSE, 8'h01, "wd_flag");
    wr(`MRS_ADDR_CAUSE, 8'h00);
    // Watchdog time-out asleep, every oscillator choice
    wr(`MRS_ADDR_LEVEL, `MRS_BO_CODE_D);
    for (k = 0; k < 5; k++) begin
      @(posedge core_clk_i);
      osc_sel_i     <= mrs_pkg::mrs_osc_e'(k[2:0]);
      sleep_idle_i  <= 1'b1;
      wdt_timeout_i <= 1'b1;
      @(posedge core_clk_i);
      wdt_timeout_i <= 1'b0;
      #1;
      `CHK("slp_pcsp", 1'b1, pc_sp_clear_o)
      `CHK("slp_to", 1'b1, to_flag_o)
      `CHK("slp_pdf", 1'b1, pdf_flag_o)
      @(posedge core_clk_i);
      #1;
      `CHK("slp_pulse", 1'b0, pc_sp_clear_o)
      `CHK("slp_norst", 1'b1, core_rst_n_o)
      `CHK("slp_wait", 1'b0, core_run_o)
      n = 1;
      while (core_run_o !== 1'b1 && n < 6000) begin
        @(posedge core_clk_i);
        #1 n++;
      end
      `CHK("sst", 1'b1, in_rng(n, (SST_LO[k] - 1) * OSCP, (SST_HI[k] + 1) * OSCP + 2))
      @(posedge core_clk_i);
      sleep_idle_i <= 1'b0;
      if (k < 4) wr(`MRS_ADDR_FLAGS, 8'h00);
    end
    // Second power-on reset in mid-run
    @(posedge core_clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    `CHK("por2_to", 1'b0, to_flag_o)
    `CHK("por2_pdf", 1'b0, pdf_flag_o)
    @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rise_wait(n);
    `CHK("por2_delay", POR, n)
    rd_chk(`MRS_ADDR_LEVEL, `MRS_BO_RST, "level_por2");
    wrap_up();
  end
endmodule
